// ===== src/mmd_pkg.sv
// package of the memory map decoder: region bounds, stack constants, push counts
// assumes a 16-bit byte address space and an 8-bit data path
package mmd_pkg;

  // ----------------------------------------------------------------
  // address regions
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_LO     = 16'h0000;
  localparam logic [15:0] REG_HI     = 16'h003F;
  localparam logic [15:0] RAM_LO     = 16'h0040;
  localparam logic [15:0] RAM_HI     = 16'h0E3F;
  localparam logic [15:0] DPAGE_END  = 16'h00FF;
  localparam logic [15:0] SYS_LO     = 16'hFE00;
  localparam logic [15:0] SYS_HI     = 16'hFE0E;
  localparam logic [15:0] MON_LO     = 16'hFE10;
  localparam logic [15:0] MON_HI     = 16'hFEFF;
  localparam logic [15:0] FLASH_LO   = 16'h1000;
  localparam logic [15:0] FLASH_HI   = 16'hFDFF;
  localparam logic [15:0] VEC_LO     = 16'hFFD0;
  localparam logic [15:0] VEC_HI     = 16'hFFFF;
  localparam int          RAM_BYTES  = 3584;

  // ----------------------------------------------------------------
  // stack conventions
  // ----------------------------------------------------------------
  localparam logic [15:0] SP_RESET   = 16'h00FF;
  localparam logic [2:0]  IRQ_PUSHES = 3'h5;
  localparam logic [2:0]  JSR_PUSHES = 3'h2;

  // ----------------------------------------------------------------
  // reset pin
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_HOLD   = 4'h8;

  // target selected by the decoder
  typedef enum logic [2:0] {
    TGT_NONE, TGT_REG, TGT_SYS, TGT_RAM, TGT_FLASH, TGT_VEC, TGT_MON
  } mmd_target_e;

  // stack sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_PULL} mmd_stack_e;

endpackage

// ===== src/mmd_region_decode.sv
// combinational address decoder for the 64-Kbyte space
// assumes the caller registers the outputs
`timescale 1ns/100ps
module mmd_region_decode (
  // address in
  input  wire logic [15:0]        addr,
  // decode out
  output mmd_pkg::mmd_target_e    target,
  output logic                    directPage
);

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // one-hot region hits
  wire hitReg   = inRange(addr, mmd_pkg::REG_LO, mmd_pkg::REG_HI);
  wire hitSys   = inRange(addr, mmd_pkg::SYS_LO, mmd_pkg::SYS_HI);
  wire hitRam   = inRange(addr, mmd_pkg::RAM_LO, mmd_pkg::RAM_HI);
  wire hitFlash = inRange(addr, mmd_pkg::FLASH_LO, mmd_pkg::FLASH_HI);
  wire hitVec   = inRange(addr, mmd_pkg::VEC_LO, mmd_pkg::VEC_HI);
  wire hitMon   = inRange(addr, mmd_pkg::MON_LO, mmd_pkg::MON_HI);

  // ram below 0x0100 is the direct-page share of 192 bytes
  assign directPage = hitRam && (addr <= mmd_pkg::DPAGE_END);

  // regions never overlap, so order only matters for readability
  assign target = hitReg   ? mmd_pkg::TGT_REG   :
                  hitSys   ? mmd_pkg::TGT_SYS   :
                  hitRam   ? mmd_pkg::TGT_RAM   :
                  hitFlash ? mmd_pkg::TGT_FLASH :
                  hitVec   ? mmd_pkg::TGT_VEC   :
                  hitMon   ? mmd_pkg::TGT_MON   :
                             mmd_pkg::TGT_NONE;

endmodule

// ===== src/mmd_memory_map.sv
// memory map decoder top: registered select strobes, stack pointer, reset pin
// assumes one 100 MHz clock; reset pin input arrives asynchronously
//
// Summary of operation
// - addresses 0x0000..0x003F select the peripheral register window
// - addresses 0xFE00..0xFE0E select the high system register group
// - addresses 0x0040..0x0E3F select on-chip ram, 3584 bytes
// - ram bytes below 0x0100 are flagged as direct page, 192 bytes
// - 64 Kbyte space also holds flash, 48 vector bytes, 240 monitor bytes
// - stack pointer is 16 bits and resets to 0x00FF
// - interrupt entry pushes five register bytes before the handler
// - interrupt stacking leaves out the index high byte
// - subroutine call pushes a two-byte return address
// - stack pointer decrements per push, increments per pull
// - device drives the reset line low while any internal reset is active
`timescale 1ns/100ps
module mmd_memory_map #(
  // address and stack pointer width; the region table is 16-bit only
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // cpu access
  input  wire logic [ADDR_W-1:0] cpuAddr,
  input  wire logic              cpuValid,
  input  wire logic              cpuWrite,
  // stack requests from the core
  input  wire logic              irqEntry,
  input  wire logic              subCall,
  input  wire logic              pullByte,
  input  wire logic              pushByte,
  // internal reset sources
  input  wire logic              intResetReq,
  // bidirectional reset pin
  input  wire logic              resetPinIn,
  output logic                   resetPinOut,
  output logic                   resetPinOe,
  output logic                   sysReset,
  // selects
  output logic                   selReg,
  output logic                   selSys,
  output logic                   selRam,
  output logic                   selFlash,
  output logic                   selVec,
  output logic                   selMon,
  output logic                   selDirect,
  output logic                   writeEn,
  output logic                   unmapped,
  // stack
  output logic [ADDR_W-1:0]      stackPtr,
  output logic                   stackBusy,
  output logic                   stackPush
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // region bounds and the stack reset value are 16-bit constants,
  // so any other width would silently mis-decode
  if (ADDR_W != 16) begin : g_bad_width
    $error("mmd_memory_map serves only a 16-bit address");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  mmd_pkg::mmd_target_e tgt;
  logic                 dpg;

  mmd_region_decode uDecode (
    .addr       (cpuAddr),
    .target     (tgt),
    .directPage (dpg)
  );

  logic selReg_reg, selSys_reg, selRam_reg, selFlash_reg;
  logic selVec_reg, selMon_reg, selDirect_reg, writeEn_reg, unmapped_reg;

  // strobes registered so every strobe output is a flop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      selReg_reg    <= 1'b0;
      selSys_reg    <= 1'b0;
      selRam_reg    <= 1'b0;
      selFlash_reg  <= 1'b0;
      selVec_reg    <= 1'b0;
      selMon_reg    <= 1'b0;
      selDirect_reg <= 1'b0;
      writeEn_reg   <= 1'b0;
      unmapped_reg  <= 1'b0;
    end else begin
      selReg_reg    <= cpuValid && (tgt == mmd_pkg::TGT_REG);
      selSys_reg    <= cpuValid && (tgt == mmd_pkg::TGT_SYS);
      selRam_reg    <= cpuValid && (tgt == mmd_pkg::TGT_RAM);
      selFlash_reg  <= cpuValid && (tgt == mmd_pkg::TGT_FLASH);
      selVec_reg    <= cpuValid && (tgt == mmd_pkg::TGT_VEC);
      selMon_reg    <= cpuValid && (tgt == mmd_pkg::TGT_MON);
      selDirect_reg <= cpuValid && dpg;
      // unmapped writes never reach any target
      writeEn_reg   <= cpuValid && cpuWrite && (tgt != mmd_pkg::TGT_NONE);
      unmapped_reg  <= cpuValid && (tgt == mmd_pkg::TGT_NONE);
    end
  end

  assign selReg    = selReg_reg;
  assign selSys    = selSys_reg;
  assign selRam    = selRam_reg;
  assign selFlash  = selFlash_reg;
  assign selVec    = selVec_reg;
  assign selMon    = selMon_reg;
  assign selDirect = selDirect_reg;
  assign writeEn   = writeEn_reg;
  assign unmapped  = unmapped_reg;

  // ----------------------------------------------------------------
  // reset pin
  // ----------------------------------------------------------------
  logic pinSync1_reg, pinSync2_reg;
  logic [3:0] holdCnt_reg, holdCnt_next;
  logic resetOe_reg, sysReset_reg;

  // pin passes two flops before anything reads it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
    end else begin
      pinSync1_reg <= resetPinIn;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  // stretch internal requests so the rest of the board sees a clean pulse
  assign holdCnt_next = intResetReq ? mmd_pkg::RST_HOLD :
                        (holdCnt_reg != 4'h0) ? holdCnt_reg - 4'h1 : 4'h0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_reg  <= 4'h0;
      resetOe_reg  <= 1'b0;
      sysReset_reg <= 1'b1;
    end else begin
      holdCnt_reg  <= holdCnt_next;
      resetOe_reg  <= (holdCnt_next != 4'h0);
      // pin low from anyone, including our own drive, resets the core
      sysReset_reg <= !pinSync2_reg || (holdCnt_next != 4'h0);
    end
  end

  assign resetPinOut = 1'b0;
  assign resetPinOe  = resetOe_reg;
  assign sysReset    = sysReset_reg;

  // ----------------------------------------------------------------
  // stack pointer and push sequencer
  // ----------------------------------------------------------------
  mmd_pkg::mmd_stack_e state_reg, state_next;
  logic [15:0] sp_reg, sp_next;
  logic [2:0]  left_reg, left_next;
  logic        push_reg;
  logic        busy_reg;

  // index high byte is never in the automatic frame, so the frame
  // is five bytes
  wire [2:0] burstLen = irqEntry ? mmd_pkg::IRQ_PUSHES :
                                   mmd_pkg::JSR_PUSHES;
  wire startBurst = (state_reg == mmd_pkg::ST_IDLE) && (irqEntry || subCall);
  wire doPush = startBurst || (state_reg == mmd_pkg::ST_PUSH) ||
                ((state_reg == mmd_pkg::ST_IDLE) && pushByte);
  wire doPull = (state_reg == mmd_pkg::ST_IDLE) && !startBurst &&
                !pushByte && pullByte;

  always_comb begin
    state_next = state_reg;
    left_next  = left_reg;
    unique case (state_reg)
      mmd_pkg::ST_IDLE: begin
        if (startBurst && burstLen > 3'h1) begin
          state_next = mmd_pkg::ST_PUSH;
          left_next  = burstLen - 3'h1;
        end
      end
      mmd_pkg::ST_PUSH: begin
        left_next = left_reg - 3'h1;
        if (left_reg == 3'h1) begin
          state_next = mmd_pkg::ST_IDLE;
        end
      end
      mmd_pkg::ST_PULL: begin
        state_next = mmd_pkg::ST_IDLE;
      end
      // the unused fourth code falls back to idle
      default: begin
        state_next = mmd_pkg::ST_IDLE;
      end
    endcase
  end

  // one byte per cycle: down on push, up on pull
  assign sp_next = doPush ? sp_reg - 16'h0001 :
                   doPull ? sp_reg + 16'h0001 : sp_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= mmd_pkg::ST_IDLE;
      left_reg  <= 3'h0;
      sp_reg    <= mmd_pkg::SP_RESET;
      push_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (sysReset_reg) begin
      state_reg <= mmd_pkg::ST_IDLE;
      left_reg  <= 3'h0;
      sp_reg    <= mmd_pkg::SP_RESET;
      push_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg  <= left_next;
      sp_reg    <= sp_next;
      push_reg  <= doPush;
      // busy is its own flop so the output needs no decode
      busy_reg  <= (state_next != mmd_pkg::ST_IDLE);
    end
  end

  assign stackPtr  = sp_reg;
  assign stackBusy = busy_reg;
  assign stackPush = push_reg;

endmodule

// ===== sim/mmd_chk.sv
// checker for the memory map decoder: decode, stack frames, reset pin drive
// assumes it is bound to mmd_memory_map and sees only its ports
`timescale 1ns/100ps
module mmd_chk (
  // clock, reset and requests
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic [15:0] cpuAddr,
  input wire logic        cpuValid,
  input wire logic        irqEntry,
  input wire logic        subCall,
  input wire logic        pushByte,
  input wire logic        pullByte,
  input wire logic        intResetReq,
  // responses
  input wire logic        resetPinOe,
  input wire logic        sysReset,
  input wire logic        selReg,
  input wire logic        selSys,
  input wire logic        selRam,
  input wire logic        selFlash,
  input wire logic        selDirect,
  input wire logic        writeEn,
  input wire logic        unmapped,
  input wire logic [15:0] stackPtr,
  input wire logic        stackBusy
);
  // held device reset restarts the stack, so frames are not judged then
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n || sysReset);
  // a stack request is taken only while no frame runs
  sequence s_take(logic req);
    req && !stackBusy;
  endsequence
  property p_reg; cpuValid && cpuAddr <= 16'h003F |=> selReg; endproperty
  a_reg: assert property (p_reg) else $error("reg window missed");
  property p_sys; cpuValid && cpuAddr inside {[16'hFE00:16'hFE0E]} |=> selSys; endproperty
  a_sys: assert property (p_sys) else $error("sys group missed");
  property p_ram; cpuValid && cpuAddr inside {[16'h0040:16'h0E3F]} |=> selRam; endproperty
  a_ram: assert property (p_ram) else $error("ram missed");
  property p_dir; cpuValid && cpuAddr inside {[16'h0040:16'h00FF]} |=> selDirect; endproperty
  a_dir: assert property (p_dir) else $error("direct page missed");
  property p_fl; cpuValid && cpuAddr inside {[16'h1000:16'hFDFF]} |=> selFlash; endproperty
  a_fl: assert property (p_fl) else $error("flash missed");
  property p_irq;
    s_take(irqEntry) |=> (stackPtr == $past(stackPtr) - 16'h0001)
      ##4 (stackPtr == $past(stackPtr, 5) - 16'h0005);
  endproperty
  a_irq: assert property (p_irq) else $error("irq frame size");
  property p_call;
    s_take(subCall) |=> (stackPtr == $past(stackPtr) - 16'h0001)
      ##1 (stackPtr == $past(stackPtr, 2) - 16'h0002);
  endproperty
  a_call: assert property (p_call) else $error("call frame size");
  property p_pull;
    s_take(pullByte && !pushByte && !irqEntry && !subCall)
      |=> stackPtr == $past(stackPtr) + 16'h0001;
  endproperty
  a_pull: assert property (p_pull) else $error("pull step");
  // own disable: the drive it checks also raises sysReset
  property p_pin; disable iff (!arst_n) intResetReq |=> resetPinOe; endproperty
  a_pin: assert property (p_pin) else $error("pin not driven");
  property p_unm;
    cpuValid && !(cpuAddr inside {[16'h0000:16'h0E3F], [16'h1000:16'hFE0E],
      [16'hFE10:16'hFEFF], [16'hFFD0:16'hFFFF]}) |=> unmapped && !writeEn && !selRam;
  endproperty
  a_unm: assert property (p_unm) else $error("hole selected");
endmodule

// ===== sim/mmd_cpu_model.sv
// cpu core model: one access per bench request
// assumes requests are one-cycle pulses set by non-blocking assignment
`timescale 1ns/100ps
module mmd_cpu_model (
  // request from the bench
  input  wire logic        clock,
  input  wire logic        reqGo,
  input  wire logic [15:0] reqAddr,
  input  wire logic        reqWrite,
  // access toward the decoder
  output logic [15:0]      cpuAddr = 16'h0000,
  output logic             cpuValid = 1'b0,
  output logic             cpuWrite = 1'b0
);
  // idle bus shows inverted values, so a stale decode cannot pass
  always @(posedge clock) begin
    cpuValid <= reqGo;
    cpuAddr  <= reqGo ? reqAddr : ~cpuAddr;
    cpuWrite <= reqGo ? reqWrite : ~cpuWrite;
  end
endmodule

// ===== sim/tb_top.sv
// bench for the memory map decoder: decode table, stack frames, reset pin
// assumes the cpu model and checker are compiled first
`timescale 1ns/100ps
module tb_top;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        reqGo = 1'b0;
  logic        reqWrite = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [3:0]  stk = 4'h0;
  logic        intResetReq = 1'b0;
  logic        extLow = 1'b0;
  logic [15:0] cpuAddr, stackPtr;
  logic        cpuValid, cpuWrite, resetPinOut, resetPinOe, sysReset, stackBusy, stackPush;
  logic        selReg, selSys, selRam, selFlash, selVec, selMon, selDirect, writeEn, unmapped;
  int          fail_count = 0;
  int          check_count = 0;
  // pin is pulled up; low when the outside or the device pulls it
  wire logic   resetPin = !(extLow || (resetPinOe && !resetPinOut));
  wire logic [8:0] selAll = {selReg, selSys, selRam, selFlash, selVec, selMon, selDirect,
                             writeEn, unmapped};
  // addr, write, expected {reg sys ram flash vec mon direct wen unmapped}
  logic [25:0] rows [15] = '{
    {16'h0000, 1'b1, 9'h102}, {16'h003F, 1'b0, 9'h100}, {16'h0040, 1'b0, 9'h044},
    {16'h00FF, 1'b1, 9'h046}, {16'h0100, 1'b0, 9'h040}, {16'h0E3F, 1'b1, 9'h042},
    {16'h0E40, 1'b1, 9'h001}, {16'h1000, 1'b0, 9'h020}, {16'hFDFF, 1'b0, 9'h020},
    {16'hFE00, 1'b1, 9'h082}, {16'hFE0E, 1'b0, 9'h080}, {16'hFE0F, 1'b0, 9'h001},
    {16'hFE10, 1'b0, 9'h008}, {16'hFFCF, 1'b0, 9'h001}, {16'hFFD0, 1'b0, 9'h010}};
  mmd_memory_map u_mmd_memory_map (
    .clock, .arst_n, .cpuAddr, .cpuValid, .cpuWrite,
    .irqEntry(stk[3]), .subCall(stk[2]), .pushByte(stk[1]), .pullByte(stk[0]),
    .intResetReq, .resetPinIn(resetPin), .resetPinOut, .resetPinOe, .sysReset,
    .selReg, .selSys, .selRam, .selFlash, .selVec, .selMon, .selDirect, .writeEn,
    .unmapped, .stackPtr, .stackBusy, .stackPush);
  mmd_cpu_model u_mmd_cpu_model (
    .clock, .reqGo, .reqAddr, .reqWrite, .cpuAddr, .cpuValid, .cpuWrite);
  always #5 clock = ~clock;
  task automatic check(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // selects land one edge after the model presents the access
  task automatic access(input logic [15:0] ad, input logic wr);
    @(posedge clock) begin
      reqGo    <= 1'b1;
      reqAddr  <= ad;
      reqWrite <= wr;
    end
    @(posedge clock) reqGo <= 1'b0;
    @(posedge clock) #1;
  endtask
  // stack request pulse {irq call push pull}, then n idle edges
  task automatic pulse(input logic [3:0] v, input int n);
    @(posedge clock) stk <= v;
    @(posedge clock) stk <= 4'h0;
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check("sp reset", stackPtr, 16'h00FF);
    check("sys reset", sysReset, 1'b0);
    $display("reset test done");
    foreach (rows[i]) begin
      access(rows[i][25:10], rows[i][9]);
      check("selects", selAll, rows[i][8:0]);
    end
    $display("decode test done");
    // a push during the frame must be refused
    pulse(4'h8, 0);
    check("busy", stackBusy, 1'b1);
    pulse(4'h2, 2);
    check("irq frame", stackPtr, 16'h00FA);
    check("idle", stackBusy, 1'b0);
    pulse(4'h4, 1);
    check("call frame", stackPtr, 16'h00F8);
    pulse(4'h2, 0);
    check("push", stackPtr, 16'h00F7);
    check("push strobe", stackPush, 1'b1);
    pulse(4'h1, 0);
    check("pull", stackPtr, 16'h00F8);
    check("pull strobe", stackPush, 1'b0);
    pulse(4'h3, 0);
    check("push over pull", stackPtr, 16'h00F7);
    $display("stack test done");
    @(posedge clock) intResetReq <= 1'b1;
    @(posedge clock) #1;
    check("pin drive", {resetPinOe, resetPinOut}, 2'b10);
    repeat (3) @(posedge clock);
    #1;
    check("pin reset", sysReset, 1'b1);
    @(posedge clock) intResetReq <= 1'b0;
    repeat (14) @(posedge clock);
    #1;
    check("pin free", {resetPinOe, sysReset}, 2'b00);
    check("sp restart", stackPtr, 16'h00FF);
    @(posedge clock) extLow <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("ext reset", sysReset, 1'b1);
    $display("reset pin test done");
    summarize();
  end
  // whole run is about 100 cycles
  initial begin
    repeat (1000) @(posedge clock);
    fail_count++;
    summarize();
  end
endmodule
bind mmd_memory_map mmd_chk u_mmd_chk (
  .clock, .arst_n, .cpuAddr, .cpuValid, .irqEntry, .subCall, .pushByte, .pullByte,
  .intResetReq, .resetPinOe, .sysReset, .selReg, .selSys, .selRam, .selFlash,
  .selDirect, .writeEn, .unmapped, .stackPtr, .stackBusy);
